// ==== core/bcdrtc_core.v ====
// BCD calendar clock core with asynchronous 4-bit strobe bus
`include "bcdrtc_consts.vh"

// How it works
// - write window is chip select and write low
// - data captured on write window trailing edge
// - read window drives addressed register onto data
// - each time digit is a 4-bit BCD register
// - unused bits read zero, writes ignore them
// - stop bit holds divider and tenths at zero
// - time advances every 100 ms, all together
// - timer delays 0.1 to 60 s, single/repeat
// - expiry pulls interrupt low until control read
// - test mode puts crystal on interrupt pin
// - fractional, 9-stage binary, Johnson divide-by-six
// - setting pulse one crystal period, clocks all
// - time and flag change at setting pulse
// - setting pulse sets flag, control read clears
// - time registers writable, tenths read only
// - 12-hour mode: one tens bit, AM/PM
// - 24-hour mode: two tens bits, AM/PM zero
// - units hours four bits, bit 0 mode
// - days wrap per month and leap counter
// - leap counter two bits, zero means leap
// - select bit steers address 15
// - interrupt bit 3 repeat, bits 2:0 delay
module bcdrtc_core (
  input wire sys_clk, // System clock, 250 MHz
  input wire arst_n, // Asynchronous reset, active low
  input wire xtal_in, // Crystal oscillator level
  input wire cs_n, // Chip select, active low
  input wire rd_n, // Read, active low
  input wire wr_n, // Write, active low
  input wire [3:0] address_lines, // Register address
  input wire [3:0] data_lines_in, // Data pins as seen
  output reg [3:0] data_lines_out_ff, // Data pins driven value
  output reg data_lines_oe_n_ff, // Data driver enable, active low
  output reg int_out_ff, // Interrupt pin driven value
  output reg int_oe_n_ff // Interrupt driver enable, active low
);

  // Three-stage synchronisers; a change counts once stages two and three agree
  wire [`BR_NPIN-1:0] pin_raw = {xtal_in, cs_n, rd_n, wr_n, address_lines, data_lines_in};
  localparam [`BR_NPIN-1:0] pin_idle = `BR_PIN_RST;
  // Each bit has its own filter flop, so the vector has one driver per bit
  wire [`BR_NPIN-1:0] pin_f_ff;
  genvar gi;
  generate
    for (gi = 0; gi < `BR_NPIN; gi = gi + 1) begin : g_sync
      reg s1_ff, s2_ff, s3_ff, f_ff;
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_ff <= pin_idle[gi];
          s2_ff <= pin_idle[gi];
          s3_ff <= pin_idle[gi];
          f_ff <= pin_idle[gi];
        end else begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            f_ff <= s3_ff;
        end
      end
      assign pin_f_ff[gi] = f_ff;
    end
  endgenerate

  wire [3:0] adr = pin_f_ff[`BR_P_AHI:`BR_P_ALO];
  wire [3:0] din = pin_f_ff[`BR_P_DHI:`BR_P_DLO];
  wire wr_win = ~pin_f_ff[`BR_P_CS] & ~pin_f_ff[`BR_P_WR];
  wire rd_win = ~pin_f_ff[`BR_P_CS] & ~pin_f_ff[`BR_P_RD];
  reg wr_win_ff, rd_win_ff, xtal_d_ff;
  reg [3:0] rd_adr_ff;
  wire wr_end = wr_win_ff & ~wr_win;
  wire rd_ctrl_end = rd_win_ff & ~rd_win & (rd_adr_ff == `BR_A_CTRL);
  wire xtal_tick = pin_f_ff[`BR_P_XTAL] & ~xtal_d_ff;

  // Control and time state
  reg test_ff, stop_ff, isel_ff, dchg_ff, iflg_ff;
  reg [3:0] ten_ff;
  reg [7:0] sec_ff, min_ff, hr_ff, day_ff, mon_ff, yr_ff;
  reg [2:0] dow_ff;
  reg [1:0] leap_ff;
  reg ampm_ff, m24_ff, irep_ff, trun_ff;
  reg [2:0] icode_ff;
  reg [`BR_TMR_W-1:0] tmr_ff;
  wire set_tick;

  bcdrtc_div u_div (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .xtal_tick(xtal_tick),
    .hold(stop_ff),
    .set_tick_ff(set_tick)
  );

  // Two-digit BCD step: {wrap, next}
  function [8:0] bcd_step;
    input [7:0] v;
    input [7:0] top;
    input [7:0] lo;
    begin
      if (v == top)
        bcd_step = {1'b1, lo};
      else if (v[3:0] == `BR_DIG_MAX)
        bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last day of a month, from month and leap counter
  function [7:0] last_day;
    input [7:0] m;
    input [1:0] lp;
    begin
      if (m == `BR_MON_FEB)
        last_day = (lp == `BR_LEAP0) ? `BR_D29 : `BR_D28;
      else if (m == `BR_MON_APR || m == `BR_MON_JUN || m == `BR_MON_SEP || m == `BR_MON_NOV)
        last_day = `BR_D30;
      else
        last_day = `BR_D31;
    end
  endfunction

  // Interrupt delay in setting pulses
  function [`BR_TMR_W-1:0] dly_ticks;
    input [2:0] c;
    reg [31:0] ms;
    reg [31:0] q;
    begin
      case (c)
        3'h1: ms = `BR_DLY1_MS;
        3'h2: ms = `BR_DLY2_MS;
        3'h3: ms = `BR_DLY3_MS;
        3'h4: ms = `BR_DLY4_MS;
        3'h5: ms = `BR_DLY5_MS;
        3'h6: ms = `BR_DLY6_MS;
        3'h7: ms = `BR_DLY7_MS;
        default: ms = 32'h0000_0000;
      endcase
      q = ms / `BR_TICK_MS;
      dly_ticks = q[`BR_TMR_W-1:0];
    end
  endfunction

  // Next time values: advance first, then a finishing write overrides its register
  reg [3:0] nxt_ten;
  reg [7:0] nxt_sec, nxt_min, nxt_hr, nxt_day, nxt_mon, nxt_yr;
  reg [2:0] nxt_dow;
  reg [1:0] nxt_leap;
  reg nxt_ampm, nxt_m24;
  reg [8:0] st;
  reg c_s, c_m, c_h, c_d, c_mo;
  always @* begin
    nxt_ten = ten_ff;
    nxt_sec = sec_ff;
    nxt_min = min_ff;
    nxt_hr = hr_ff;
    nxt_day = day_ff;
    nxt_mon = mon_ff;
    nxt_yr = yr_ff;
    nxt_dow = dow_ff;
    nxt_leap = leap_ff;
    nxt_ampm = ampm_ff;
    nxt_m24 = m24_ff;
    st = 9'h000;
    c_s = 1'b0;
    c_m = 1'b0;
    c_h = 1'b0;
    c_d = 1'b0;
    c_mo = 1'b0;
    if (stop_ff) begin
      nxt_ten = 4'h0;
    end else if (set_tick) begin
      c_s = (ten_ff == `BR_DIG_MAX);
      nxt_ten = c_s ? 4'h0 : ten_ff + 4'h1;
      if (c_s) begin
        st = bcd_step(sec_ff, `BR_SEC_TOP, `BR_Z8);
        nxt_sec = st[7:0];
        c_m = st[8];
      end
      if (c_m) begin
        st = bcd_step(min_ff, `BR_SEC_TOP, `BR_Z8);
        nxt_min = st[7:0];
        c_h = st[8];
      end
      if (c_h) begin
        if (m24_ff) begin
          st = bcd_step(hr_ff, `BR_HR24TOP, `BR_Z8);
          nxt_hr = st[7:0];
          c_d = st[8];
        end else begin
          st = bcd_step(hr_ff, `BR_HR12TOP, `BR_ONE8);
          nxt_hr = st[7:0];
          if (hr_ff == `BR_HR12PRE) begin
            nxt_ampm = ~ampm_ff;
            c_d = ampm_ff;
          end
        end
      end
      if (c_d) begin
        nxt_dow = (dow_ff == `BR_DOW_TOP) ? `BR_DOW_LO : dow_ff + 3'h1;
        st = bcd_step(day_ff, last_day(mon_ff, leap_ff), `BR_ONE8);
        nxt_day = st[7:0];
        c_mo = st[8];
      end
      if (c_mo) begin
        st = bcd_step(mon_ff, `BR_MON_TOP, `BR_ONE8);
        nxt_mon = st[7:0];
        if (st[8]) begin
          st = bcd_step(yr_ff, `BR_YR_TOP, `BR_Z8);
          nxt_yr = st[7:0];
          nxt_leap = leap_ff + 2'h1;
        end
      end
    end
    // Writes keep only implemented bits
    if (wr_end) begin
      case (adr)
        `BR_A_SECU: nxt_sec = {sec_ff[7:4], din};
        `BR_A_SECT: nxt_sec = {1'b0, din[2:0], sec_ff[3:0]};
        `BR_A_MINU: nxt_min = {min_ff[7:4], din};
        `BR_A_MINT: nxt_min = {1'b0, din[2:0], min_ff[3:0]};
        `BR_A_HRU: nxt_hr = {hr_ff[7:4], din};
        `BR_A_HRT: nxt_hr = m24_ff ? {2'b00, din[1:0], hr_ff[3:0]}
                                   : {3'b000, din[0], hr_ff[3:0]};
        `BR_A_DAYU: nxt_day = {day_ff[7:4], din};
        `BR_A_DAYT: nxt_day = {2'b00, din[1:0], day_ff[3:0]};
        `BR_A_MONU: nxt_mon = {mon_ff[7:4], din};
        `BR_A_MONT: nxt_mon = {3'b000, din[0], mon_ff[3:0]};
        `BR_A_YRU: nxt_yr = {yr_ff[7:4], din};
        `BR_A_YRT: nxt_yr = {din, yr_ff[3:0]};
        `BR_A_DOW: nxt_dow = din[2:0];
        `BR_A_SET: begin
          if (!isel_ff) begin
            nxt_leap = din[`BR_SB_LPHI:`BR_SB_LPLO];
            nxt_m24 = din[`BR_SB_M24];
            // Mode and AM/PM cannot change together; a mode change drops AM/PM
            if (din[`BR_SB_M24])
              nxt_ampm = 1'b0;
            else if (!m24_ff)
              nxt_ampm = din[`BR_SB_AMPM];
          end
        end
        default: nxt_ten = nxt_ten; // Tenths and control are not time writes
      endcase
    end
  end

  // Read data for the address held during the window
  reg [3:0] rd_val;
  always @* begin
    case (adr)
      `BR_A_CTRL: rd_val = {dchg_ff, 2'b00, iflg_ff};
      `BR_A_TEN: rd_val = ten_ff;
      `BR_A_SECU: rd_val = sec_ff[3:0];
      `BR_A_SECT: rd_val = {1'b0, sec_ff[6:4]};
      `BR_A_MINU: rd_val = min_ff[3:0];
      `BR_A_MINT: rd_val = {1'b0, min_ff[6:4]};
      `BR_A_HRU: rd_val = hr_ff[3:0];
      `BR_A_HRT: rd_val = m24_ff ? {2'b00, hr_ff[5:4]} : {3'b000, hr_ff[4]};
      `BR_A_DAYU: rd_val = day_ff[3:0];
      `BR_A_DAYT: rd_val = {2'b00, day_ff[5:4]};
      `BR_A_MONU: rd_val = mon_ff[3:0];
      `BR_A_MONT: rd_val = {3'b000, mon_ff[4]};
      `BR_A_YRU: rd_val = yr_ff[3:0];
      `BR_A_YRT: rd_val = yr_ff[7:4];
      `BR_A_DOW: rd_val = {1'b0, dow_ff};
      `BR_A_SET: rd_val = isel_ff ? {irep_ff, icode_ff}
                                  : {leap_ff, ampm_ff & ~m24_ff, m24_ff};
      default: rd_val = 4'h0;
    endcase
  end

  wire int_wr = wr_end & (adr == `BR_A_SET) & isel_ff;
  wire tmr_exp = set_tick & trun_ff & (tmr_ff == `BR_TMR_ONE);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_win_ff <= 1'b0;
      rd_win_ff <= 1'b0;
      rd_adr_ff <= 4'h0;
      xtal_d_ff <= 1'b0;
      test_ff <= 1'b0;
      stop_ff <= 1'b1;
      isel_ff <= 1'b0;
      dchg_ff <= 1'b0;
      iflg_ff <= 1'b0;
      ten_ff <= 4'h0;
      sec_ff <= `BR_Z8;
      min_ff <= `BR_Z8;
      hr_ff <= `BR_RST_HR;
      day_ff <= `BR_RST_DAY;
      mon_ff <= `BR_RST_MON;
      yr_ff <= `BR_Z8;
      dow_ff <= `BR_DOW_LO;
      leap_ff <= `BR_LEAP0;
      ampm_ff <= 1'b0;
      m24_ff <= 1'b0;
      irep_ff <= 1'b0;
      icode_ff <= 3'h0;
      trun_ff <= 1'b0;
      tmr_ff <= {`BR_TMR_W{1'b0}};
      data_lines_out_ff <= 4'h0;
      data_lines_oe_n_ff <= 1'b1;
      int_out_ff <= 1'b0;
      int_oe_n_ff <= 1'b1;
    end else begin
      wr_win_ff <= wr_win;
      rd_win_ff <= rd_win;
      if (rd_win)
        rd_adr_ff <= adr;
      xtal_d_ff <= pin_f_ff[`BR_P_XTAL];
      ten_ff <= nxt_ten;
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hr_ff <= nxt_hr;
      day_ff <= nxt_day;
      mon_ff <= nxt_mon;
      yr_ff <= nxt_yr;
      dow_ff <= nxt_dow;
      leap_ff <= nxt_leap;
      ampm_ff <= nxt_ampm;
      m24_ff <= nxt_m24;
      if (wr_end && adr == `BR_A_CTRL) begin
        test_ff <= din[`BR_CB_TEST];
        stop_ff <= din[`BR_CB_STOP];
        isel_ff <= din[`BR_CB_ISEL];
      end
      // Set wins over the clear made by a control read
      if (set_tick)
        dchg_ff <= 1'b1;
      else if (rd_ctrl_end)
        dchg_ff <= 1'b0;
      // Timer counts setting pulses; repeat reloads so errors never accumulate
      if (int_wr) begin
        irep_ff <= din[`BR_IB_REP];
        icode_ff <= din[2:0];
        tmr_ff <= dly_ticks(din[2:0]);
        trun_ff <= (din[2:0] != 3'h0);
      end else if (tmr_exp) begin
        tmr_ff <= dly_ticks(icode_ff);
        trun_ff <= irep_ff;
      end else if (set_tick && trun_ff) begin
        tmr_ff <= tmr_ff - `BR_TMR_ONE;
      end
      if (tmr_exp)
        iflg_ff <= 1'b1;
      else if (rd_ctrl_end || (int_wr && din[2:0] == 3'h0))
        iflg_ff <= 1'b0;
      data_lines_out_ff <= rd_val;
      data_lines_oe_n_ff <= ~rd_win;
      if (test_ff) begin
        int_out_ff <= pin_f_ff[`BR_P_XTAL];
        int_oe_n_ff <= 1'b0;
      end else begin
        int_out_ff <= 1'b0;
        int_oe_n_ff <= ~iflg_ff;
      end
    end
  end

endmodule

// ==== core/bcdrtc_consts.vh ====
// Shared constants of the BCD calendar clock core
`ifndef BCDRTC_CONSTS_VH
`define BCDRTC_CONSTS_VH

// Register addresses
`define BR_A_CTRL 4'h0
`define BR_A_TEN  4'h1
`define BR_A_SECU 4'h2
`define BR_A_SECT 4'h3
`define BR_A_MINU 4'h4
`define BR_A_MINT 4'h5
`define BR_A_HRU  4'h6
`define BR_A_HRT  4'h7
`define BR_A_DAYU 4'h8
`define BR_A_DAYT 4'h9
`define BR_A_MONU 4'hA
`define BR_A_MONT 4'hB
`define BR_A_YRU  4'hC
`define BR_A_YRT  4'hD
`define BR_A_DOW  4'hE
`define BR_A_SET  4'hF

// Control register bits
`define BR_CB_TEST 3
`define BR_CB_STOP 2
`define BR_CB_ISEL 1
`define BR_CB_DCHG 3
`define BR_CB_IFLG 0
// Clock setting and interrupt register bits
`define BR_SB_M24  0
`define BR_SB_AMPM 1
`define BR_SB_LPLO 2
`define BR_SB_LPHI 3
`define BR_IB_REP  3

// Synchronised pin vector layout and idle levels
`define BR_NPIN    12
`define BR_P_XTAL  11
`define BR_P_CS    10
`define BR_P_RD    9
`define BR_P_WR    8
`define BR_P_AHI   7
`define BR_P_ALO   4
`define BR_P_DHI   3
`define BR_P_DLO   0
`define BR_PIN_RST 12'h0700

// Divider chain: keep 15 of 16 crystal edges, 9 binary stages, 3 Johnson stages
`define BR_FRAC_LAST 4'hF
`define BR_BIN_LAST  9'h1FF
`define BR_JON_RST   3'h0
`define BR_JON_WRAP  3'h4

// BCD counting limits
`define BR_DIG_MAX 4'h9
`define BR_Z8      8'h00
`define BR_SEC_TOP 8'h59
`define BR_HR24TOP 8'h23
`define BR_HR12TOP 8'h12
`define BR_HR12PRE 8'h11
`define BR_ONE8    8'h01
`define BR_MON_TOP 8'h12
`define BR_MON_FEB 8'h02
`define BR_MON_APR 8'h04
`define BR_MON_JUN 8'h06
`define BR_MON_SEP 8'h09
`define BR_MON_NOV 8'h11
`define BR_D28     8'h28
`define BR_D29     8'h29
`define BR_D30     8'h30
`define BR_D31     8'h31
`define BR_YR_TOP  8'h99
`define BR_DOW_TOP 3'h7
`define BR_DOW_LO  3'h1
`define BR_LEAP0   2'h0

// Interrupt delays in ms, and the setting pulse period in ms
`define BR_TICK_MS 100
`define BR_DLY1_MS 100
`define BR_DLY2_MS 500
`define BR_DLY3_MS 1000
`define BR_DLY4_MS 5000
`define BR_DLY5_MS 10000
`define BR_DLY6_MS 30000
`define BR_DLY7_MS 60000
`define BR_TMR_W   10
`define BR_TMR_ONE 10'h001

// Reset values
`define BR_RST_HR  8'h12
`define BR_RST_DAY 8'h01
`define BR_RST_MON 8'h01

`endif

// ==== core/bcdrtc_div.v ====
// Crystal divider chain producing the 10 Hz setting pulse
`include "bcdrtc_consts.vh"

module bcdrtc_div (
  input wire sys_clk, // System clock
  input wire arst_n, // Asynchronous reset, active low
  input wire xtal_tick, // One pulse per crystal rising edge
  input wire hold, // Start/stop bit: holds the chain at zero
  output reg set_tick_ff // One-cycle setting pulse, 10 Hz
);

  reg [3:0] frac_ff;
  reg [8:0] bin_ff;
  reg [2:0] jon_ff;
  wire keep = xtal_tick & (frac_ff != `BR_FRAC_LAST);
  wire bin_wrap = keep & (bin_ff == `BR_BIN_LAST);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frac_ff <= 4'h0;
      bin_ff <= 9'h000;
      jon_ff <= `BR_JON_RST;
      set_tick_ff <= 1'b0;
    end else if (hold) begin
      frac_ff <= 4'h0;
      bin_ff <= 9'h000;
      jon_ff <= `BR_JON_RST;
      set_tick_ff <= 1'b0;
    end else begin
      // Dropping one edge in sixteen gives 30.720 kHz on average
      if (xtal_tick)
        frac_ff <= frac_ff + 4'h1;
      if (keep)
        bin_ff <= bin_ff + 9'h001;
      if (bin_wrap)
        jon_ff <= {jon_ff[1:0], ~jon_ff[2]};
      // Pulse lasts one cycle, standing for one crystal period
      set_tick_ff <= bin_wrap & (jon_ff == `BR_JON_WRAP);
    end
  end

endmodule

// ==== sim/bcdrtc_host.sv ====
// Host model driving the asynchronous strobe bus of the clock core
module bcdrtc_host (
  input wire logic sys_clk, // Paces the strobes
  input wire logic data_lines_oe_n_ff, // Device data driver enable
  input wire logic [3:0] data_pins, // Resolved data lines
  output logic cs_n, // Chip select
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic [3:0] address_lines, // Register address
  output logic host_drv, // Host drives the data lines
  output logic [3:0] host_data // Value the host drives
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'h1;
    rd_n = 1'h1;
    wr_n = 1'h1;
    address_lines = 4'h0;
    host_drv = 1'h0;
    host_data = 4'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [3:0] d);
    address_lines = a;
    host_drv = 1'h1;
    host_data = d;
    step(6);
    cs_n = 1'h0;
    wr_n = 1'h0;
    step(8);
    wr_n = 1'h1; // Data held past the trailing edge so it is latched there
    cs_n = 1'h1;
    step(6);
    host_drv = 1'h0; // Released lines fall back to the pull-ups
    step(8);
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [3:0] d);
    int n;
    n = 0;
    address_lines = a;
    step(6);
    cs_n = 1'h0;
    rd_n = 1'h0;
    while (data_lines_oe_n_ff !== 1'h0 && n < 16) begin
      step(1);
      n++;
    end
    step(2);
    d = (n < 16) ? data_pins : 4'hx;
    rd_n = 1'h1; // Strobe kept to a few cycles, far below the long-read limit
    cs_n = 1'h1;
    step(10);
  endtask
endmodule

// ==== sim/bcdrtc_core_props.sv ====
// Port-level checker for the clock core
module bcdrtc_core_props (
  input wire sys_clk, // Clock
  input wire arst_n, // Reset, active low
  input wire xtal_in, // Crystal level
  input wire cs_n, // Chip select
  input wire rd_n, // Read strobe
  input wire wr_n, // Write strobe
  input wire [3:0] address_lines, // Address
  input wire [3:0] data_lines_in, // Data pins
  input wire [3:0] data_lines_out_ff, // Read data
  input wire data_lines_oe_n_ff, // Data enable
  input wire int_out_ff, // Interrupt value
  input wire int_oe_n_ff // Interrupt enable
);
  logic wwin_ff, test_ff;
  logic [3:0] test_cnt_ff;
  logic [4:0] since_cs_ff;
  wire wr_end = wwin_ff && (cs_n || wr_n) && address_lines == 4'h0;
  // Test bit tracked from the pins; the counter gives the core time to follow
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wwin_ff <= 1'h0;
      test_ff <= 1'h0;
      test_cnt_ff <= 4'h0;
      since_cs_ff <= 5'h1f;
    end else begin
      wwin_ff <= !cs_n && !wr_n;
      since_cs_ff <= !cs_n ? 5'h00 : (since_cs_ff == 5'h1f ? since_cs_ff : since_cs_ff + 5'h01);
      if (wr_end && data_lines_in[3] != test_ff) begin
        test_ff <= data_lines_in[3];
        test_cnt_ff <= 4'h0;
      end else if (test_cnt_ff != 4'hf) begin
        test_cnt_ff <= test_cnt_ff + 4'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_open;
    (!cs_n && !rd_n) [*6];
  endsequence
  sequence s_rd_idle;
    (cs_n || rd_n) [*8];
  endsequence
  property p_rd_drive;
    s_rd_open |-> !data_lines_oe_n_ff;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read window not driven");
  property p_rd_release;
    s_rd_idle |-> data_lines_oe_n_ff;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("data driven outside read");
  property p_rd_cause;
    $fell(data_lines_oe_n_ff) |-> !$past(cs_n, 3) && !$past(rd_n, 3);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("drive without read window");
  property p_wr_nodrive;
    (!cs_n && !wr_n && rd_n) [*8] |-> data_lines_oe_n_ff;
  endproperty
  a_wr_nodrive: assert property (p_wr_nodrive) else $error("data driven in write");
  property p_int_release;
    ($rose(int_oe_n_ff) && !test_ff && test_cnt_ff == 4'hf) |-> since_cs_ff < 5'h14;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt freed alone");
  property p_rst_idle;
    $rose(arst_n) |-> data_lines_oe_n_ff && int_oe_n_ff && !int_out_ff;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle at reset");
  property p_test_toggle;
    (test_ff && test_cnt_ff == 4'hf) |-> ##[1:8] $changed(int_out_ff);
  endproperty
  a_test_toggle: assert property (p_test_toggle) else $error("no crystal on pin");
  property p_test_quiet;
    (!test_ff && test_cnt_ff == 4'hf) |-> !int_out_ff;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("pin toggles off test");
endmodule
bind bcdrtc_core bcdrtc_core_props u_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .xtal_in(xtal_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .address_lines(address_lines),
  .data_lines_in(data_lines_in), .data_lines_out_ff(data_lines_out_ff),
  .data_lines_oe_n_ff(data_lines_oe_n_ff), .int_out_ff(int_out_ff), .int_oe_n_ff(int_oe_n_ff));

// ==== sim/tb.sv ====
// Self-checking testbench for the clock core
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, xtal_in;
  wire cs_n, rd_n, wr_n, host_drv, data_oe_n, int_out, int_oe_n;
  wire [3:0] address_lines, host_data, data_out;
  wire [3:0] data_pins = !data_oe_n ? data_out : (host_drv ? host_data : 4'hf);
  wire int_pin = int_oe_n ? 1'h1 : int_out; // Open drain with pull-up
  int failures, num_checks, cyc, t0;
  localparam logic [3:0] rw_a [10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hb, 4'he, 4'hd, 4'h1};
  localparam logic [3:0] rw_w [10] = '{4'h7, 4'hd, 4'h9, 4'hc, 4'hf, 4'he, 4'hf, 4'hd, 4'h9, 4'h5};
  localparam logic [3:0] rw_e [10] = '{4'h7, 4'h5, 4'h9, 4'h4, 4'h1, 4'h2, 4'h1, 4'h5, 4'h9, 4'h0};
  bcdrtc_core u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .xtal_in(xtal_in), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .address_lines(address_lines), .data_lines_in(data_pins),
    .data_lines_out_ff(data_out), .data_lines_oe_n_ff(data_oe_n), .int_out_ff(int_out),
    .int_oe_n_ff(int_oe_n));
  bcdrtc_host u_host (.sys_clk(sys_clk), .data_lines_oe_n_ff(data_oe_n), .data_pins(data_pins),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .address_lines(address_lines),
    .host_drv(host_drv), .host_data(host_data));
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Crystal sped up to four system cycles per period to keep the run short
  initial begin
    xtal_in = 1'h0;
    forever #8 xtal_in = ~xtal_in;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [3:0] e);
    logic [3:0] d;
    u_host.bus_read(a, d);
    chk4($sformatf("register %h", a), e, d);
  endtask
  task automatic wait_int();
    int n;
    n = 0;
    while (int_pin !== 1'h0 && n < 15000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset_values();
    rd_chk(4'h0, 4'h0);
    rd_chk(4'h6, 4'h2);
    rd_chk(4'h7, 4'h1);
    rd_chk(4'h8, 4'h1);
    rd_chk(4'ha, 4'h1);
    rd_chk(4'he, 4'h1);
    rd_chk(4'hf, 4'h0);
  endtask
  task automatic t_rw_regs();
    for (int i = 0; i < 10; i++) begin
      u_host.bus_write(rw_a[i], rw_w[i]);
      rd_chk(rw_a[i], rw_e[i]);
    end
    u_host.bus_write(4'hf, 4'h1);
    rd_chk(4'hf, 4'h1);
    u_host.bus_write(4'hf, 4'h3);
    rd_chk(4'hf, 4'h1);
    u_host.bus_write(4'h7, 4'he);
    rd_chk(4'h7, 4'h2);
    u_host.bus_write(4'hf, 4'hc);
    rd_chk(4'hf, 4'hc);
    u_host.bus_write(4'h0, 4'h6);
    u_host.bus_write(4'hf, 4'h9);
    rd_chk(4'hf, 4'h9);
    u_host.bus_write(4'h0, 4'h4);
    rd_chk(4'hf, 4'hc);
  endtask
  task automatic t_run();
    u_host.bus_write(4'h0, 4'h0);
    rd_chk(4'h0, 4'h0);
    wait_int();
    t0 = cyc;
    chk1("interrupt first", 1'h0, int_pin);
    rd_chk(4'h1, 4'h1);
    rd_chk(4'h2, 4'h7);
    rd_chk(4'h0, 4'h9);
    chk1("interrupt freed", 1'h1, int_pin);
    rd_chk(4'h0, 4'h0);
    wait_int();
    chk1("interrupt repeat", 1'h0, int_pin);
    chk1("tick period", 1'h1, cyc - t0 >= 13095 && cyc - t0 <= 13120);
    rd_chk(4'h1, 4'h2);
    u_host.bus_write(4'h0, 4'h4);
    rd_chk(4'h1, 4'h0);
    rd_chk(4'h0, 4'h9);
  endtask
  task automatic t_test_mode();
    int cnt;
    logic prev;
    u_host.bus_write(4'h0, 4'hc);
    cnt = 0;
    prev = int_pin;
    repeat (64) begin
      u_host.step(1);
      if (int_pin !== prev) cnt++;
      prev = int_pin;
    end
    chk1("test toggles", 1'h1, cnt >= 16);
    u_host.bus_write(4'h0, 4'h4);
    cnt = 0;
    repeat (64) begin
      u_host.step(1);
      if (int_pin !== 1'h1) cnt++;
    end
    chk1("test off quiet", 1'h1, cnt == 0);
  endtask
  initial begin
    failures = 0;
    num_checks = 0;
    cyc = 0;
    arst_n = 1'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    arst_n = 1'h1;
    u_host.step(8);
    t_reset_values();
    t_rw_regs();
    t_run();
    t_test_mode();
    conclude();
  end
endmodule
